/* File: isc_device.sv */
// Behaviour
// - amp-low routed to pin/status by bit3
// - zero-count routed to pin/status by bit2
// - data-ready routed to pin/status by bit0
// - host writes zero to reserved bit 1 of error config and bit 8 of main config
// - bits 15:14 pick single channel
// - bit 13 sleep, resets to one
// - bit 12 enables drive current override
// - bit 11 selects sensor startup mode
// - bit 10 disables correction, freezes measurement
// - host should disable correction for precision
// - bit 9 selects external reference
// - bit 7 holds interrupt pin high
// - bit 6 boosts channel 0 drive
// - host avoids boost with scan enabled
// - host writes low config bits 000001
// - mux bit 15 enables channel scan
// - mux bits 14:13 pick scan sequence
// - mux bits 2:0 pick deglitch bandwidth
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module isc_device import isc_pkg::*; #(
  parameter int NUM_CHANNELS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  isc_link_if.device link,
  // conversion core events
  input wire logic amp_low_evt,
  input wire logic zero_count_evt,
  input wire logic conv_done_evt,
  // conversion core controls
  output logic [1:0] conv_channel,
  output logic sleep_mode,
  output logic drive_current_override_enable,
  output logic sensor_startup_mode_select,
  output logic amplitude_correction_disable,
  output logic measured_drive_update_en,
  output logic reference_source_select,
  output logic boosted_drive_ch0,
  output logic [2:0] deglitch_select
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [15:0] err_cfg_q;
  logic [15:0] main_cfg_q;
  logic [15:0] mux_cfg_q;
  logic wr_hit;

  assign wr_hit = link.wr && !link.ack;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_cfg_q <= ISC_ERR_CFG_RST;
    end else if (wr_hit && link.addr == ISC_ERR_CFG_ADDR) begin
      err_cfg_q <= link.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_cfg_q <= ISC_MAIN_CFG_RST;
    end else if (wr_hit && link.addr == ISC_MAIN_CFG_ADDR) begin
      main_cfg_q <= link.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mux_cfg_q <= ISC_MUX_CFG_RST;
    end else if (wr_hit && link.addr == ISC_MUX_CFG_ADDR) begin
      mux_cfg_q <= link.wdata;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic amp_low_flag_q;
  logic zero_count_status_flag_q;
  logic data_ready_status_flag_q;
  logic status_rd;

  // read of status clears flags; a new event in the same cycle wins
  assign status_rd = link.rd && !link.ack && link.addr == ISC_STATUS_ADDR;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      amp_low_flag_q <= 1'b0;
    end else if (amp_low_evt && err_cfg_q[ISC_AMP_LOW_TO_IRQ]) begin
      amp_low_flag_q <= 1'b1;
    end else if (status_rd) begin
      amp_low_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      zero_count_status_flag_q <= 1'b0;
    end else if (zero_count_evt && err_cfg_q[ISC_ZERO_COUNT_TO_IRQ]) begin
      zero_count_status_flag_q <= 1'b1;
    end else if (status_rd) begin
      zero_count_status_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // channel sequencing
  // ----------------------------------------------------------------
  logic [1:0] scan_last;
  logic [1:0] scan_ch_q;
  logic [1:0] max_ch;
  logic seq_end;

  assign max_ch = 2'(NUM_CHANNELS - 1);

  always_comb begin
    case (mux_cfg_q[ISC_SEQ_HI:ISC_SEQ_LO])
      2'h1: scan_last = 2'h2;
      2'h2: scan_last = 2'h3;
      default: scan_last = 2'h1;
    endcase
    if (scan_last > max_ch) begin
      scan_last = max_ch;
    end
  end

  assign seq_end = scan_ch_q >= scan_last;

  // scan steps one channel per conversion
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_ch_q <= 2'h0;
    end else if (!mux_cfg_q[ISC_SCAN_EN] || main_cfg_q[ISC_SLEEP]) begin
      scan_ch_q <= 2'h0;
    end else if (conv_done_evt) begin
      scan_ch_q <= seq_end ? 2'h0 : scan_ch_q + 2'h1;
    end
  end

  // data-ready; in scan only after the whole sequence
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_ready_status_flag_q <= 1'b0;
    end else if (conv_done_evt && err_cfg_q[ISC_DATA_READY_TO_IRQ]
                 && (!mux_cfg_q[ISC_SCAN_EN] || seq_end)) begin
      data_ready_status_flag_q <= 1'b1;
    end else if (status_rd) begin
      data_ready_status_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link answer
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] rdata_d;

  always_comb begin
    status_word = 16'h0000;
    status_word[ISC_ST_AMP_LOW] = amp_low_flag_q;
    status_word[ISC_ST_ZERO_COUNT] = zero_count_status_flag_q;
    status_word[ISC_ST_DATA_READY] = data_ready_status_flag_q;
  end

  // unmapped addresses read zero
  always_comb begin
    case (link.addr)
      ISC_STATUS_ADDR: rdata_d = status_word;
      ISC_ERR_CFG_ADDR: rdata_d = err_cfg_q;
      ISC_MAIN_CFG_ADDR: rdata_d = main_cfg_q;
      ISC_MUX_CFG_ADDR: rdata_d = mux_cfg_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // ack one cycle after request; host drops request on ack
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.ack <= 1'b0;
      link.rdata <= 16'h0000;
    end else begin
      link.ack <= (link.wr || link.rd) && !link.ack;
      if (link.rd && !link.ack) begin
        link.rdata <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  // disable holds pin released
  // pin low on any set flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.irq_oe_n <= 1'b1;
    end else begin
      link.irq_oe_n <= main_cfg_q[ISC_IRQ_PIN_DIS] ||
                       !(amp_low_flag_q || zero_count_status_flag_q
                         || data_ready_status_flag_q);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.irq_o <= 1'b0;
    end else begin
      link.irq_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // core controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_channel <= 2'h0;
    end else if (mux_cfg_q[ISC_SCAN_EN]) begin
      conv_channel <= scan_ch_q;
    end else begin
      // single channel, clamped to fitted channels
      conv_channel <= (main_cfg_q[ISC_SINGLE_CH_HI:ISC_SINGLE_CH_LO] > max_ch) ?
                      max_ch : main_cfg_q[ISC_SINGLE_CH_HI:ISC_SINGLE_CH_LO];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_mode <= 1'b1;
      drive_current_override_enable <= 1'b0;
      sensor_startup_mode_select <= 1'b1;
      amplitude_correction_disable <= 1'b0;
      measured_drive_update_en <= 1'b0;
      reference_source_select <= 1'b0;
      boosted_drive_ch0 <= 1'b0;
      deglitch_select <= 3'h7;
    end else begin
      sleep_mode <= main_cfg_q[ISC_SLEEP];
      drive_current_override_enable <= main_cfg_q[ISC_OVERRIDE];
      sensor_startup_mode_select <= main_cfg_q[ISC_STARTUP];
      amplitude_correction_disable <= main_cfg_q[ISC_AMP_CORR_DIS];
      measured_drive_update_en <= !main_cfg_q[ISC_AMP_CORR_DIS] && conv_done_evt;
      reference_source_select <= main_cfg_q[ISC_REF_SRC];
      // boost only on channel 0, never while scanning
      boosted_drive_ch0 <= main_cfg_q[ISC_BOOST_CH0] && !mux_cfg_q[ISC_SCAN_EN];
      deglitch_select <= mux_cfg_q[ISC_DEGLITCH_HI:0];
    end
  end

endmodule : isc_device

/* File: isc_pkg.sv */
package isc_pkg;

  // ----------------------------------------------------------------
  // link register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ISC_STATUS_ADDR = 8'h18;
  localparam logic [7:0] ISC_ERR_CFG_ADDR = 8'h19;
  localparam logic [7:0] ISC_MAIN_CFG_ADDR = 8'h1A;
  localparam logic [7:0] ISC_MUX_CFG_ADDR = 8'h1B;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ISC_ERR_CFG_RST = 16'h0000;
  localparam logic [15:0] ISC_MAIN_CFG_RST = 16'h2801;
  localparam logic [15:0] ISC_MUX_CFG_RST = 16'h020F;

  // ----------------------------------------------------------------
  // error_report_config fields
  // ----------------------------------------------------------------
  localparam int ISC_AMP_LOW_TO_IRQ = 3;
  localparam int ISC_ZERO_COUNT_TO_IRQ = 2;
  localparam int ISC_ERR_RSVD_BIT = 1;
  localparam int ISC_DATA_READY_TO_IRQ = 0;

  // ----------------------------------------------------------------
  // main_configuration fields
  // ----------------------------------------------------------------
  localparam int ISC_SINGLE_CH_HI = 15;
  localparam int ISC_SINGLE_CH_LO = 14;
  localparam int ISC_SLEEP = 13;
  localparam int ISC_OVERRIDE = 12;
  localparam int ISC_STARTUP = 11;
  localparam int ISC_AMP_CORR_DIS = 10;
  localparam int ISC_REF_SRC = 9;
  localparam int ISC_CFG_RSVD_BIT = 8;
  localparam int ISC_IRQ_PIN_DIS = 7;
  localparam int ISC_BOOST_CH0 = 6;
  localparam logic [5:0] ISC_CFG_LOW_RSVD = 6'h01;

  // ----------------------------------------------------------------
  // channel_mux_configuration fields
  // ----------------------------------------------------------------
  localparam int ISC_SCAN_EN = 15;
  localparam int ISC_SEQ_HI = 14;
  localparam int ISC_SEQ_LO = 13;
  localparam int ISC_DEGLITCH_HI = 2;

  // ----------------------------------------------------------------
  // status flag positions (own status word)
  // ----------------------------------------------------------------
  localparam int ISC_ST_AMP_LOW = 9;
  localparam int ISC_ST_ZERO_COUNT = 8;
  localparam int ISC_ST_DATA_READY = 6;

  // ----------------------------------------------------------------
  // host avalon map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [2:0] ISC_AV_CMD = 3'h0;
  localparam logic [2:0] ISC_AV_WDATA = 3'h1;
  localparam logic [2:0] ISC_AV_GO = 3'h2;
  localparam logic [2:0] ISC_AV_RESULT = 3'h3;
  localparam logic [2:0] ISC_AV_IRQ_STATUS = 3'h4;
  localparam logic [2:0] ISC_AV_IRQ_CLEAR = 3'h5;
  localparam logic [2:0] ISC_AV_IRQ_ENABLE = 3'h6;
  localparam int ISC_CMD_READ_BIT = 8;
  localparam int ISC_RES_BUSY_BIT = 16;
  localparam int ISC_EV_DONE = 0;
  localparam int ISC_EV_DEV_IRQ = 1;

  typedef enum logic [2:0] {
    ISC_H_IDLE = 3'b001,
    ISC_H_REQ = 3'b010,
    ISC_H_DONE = 3'b100
  } isc_host_state_t;

endpackage : isc_pkg

/* File: isc_link_if.sv */
`timescale 1ns/1ps
interface isc_link_if;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic ack;
  logic [15:0] rdata;
  logic irq_o;
  logic irq_oe_n;
  logic irq_line;

  // pulled-up open-drain line
  assign irq_line = irq_oe_n ? 1'b1 : irq_o;

  modport device (input addr, input wdata, input wr, input rd, output ack, output rdata,
                  output irq_o, output irq_oe_n);
  modport host (output addr, output wdata, output wr, output rd, input ack, input rdata,
                input irq_line);
endinterface : isc_link_if

/* File: isc_host.sv */
`timescale 1ns/1ps
module isc_host import isc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // link
  isc_link_if.host link
);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [8:0] cmd_q;
  logic [15:0] wdata_q;
  logic [15:0] result_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_enable_q;
  logic scan_shadow_q;
  isc_host_state_t state_q;
  logic acc;
  logic wr_acc;
  logic go;
  logic done_ev;
  logic irq_ev;
  logic [1:0] pin_sync_q;
  logic pin_prev_q;
  logic [15:0] send_data;

  assign acc = (avs_read || avs_write) && avs_waitrequest;
  // waitrequest drops for one cycle; writes act at that edge
  assign wr_acc = avs_write && !avs_waitrequest;
  assign go = wr_acc && avs_address == ISC_AV_GO && state_q == ISC_H_IDLE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !acc;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_q <= 9'h000;
      wdata_q <= 16'h0000;
      irq_enable_q <= 2'h0;
    end else if (wr_acc) begin
      if (avs_address == ISC_AV_CMD) begin
        cmd_q <= avs_writedata[8:0];
      end
      if (avs_address == ISC_AV_WDATA) begin
        wdata_q <= avs_writedata[15:0];
      end
      if (avs_address == ISC_AV_IRQ_ENABLE) begin
        irq_enable_q <= avs_writedata[1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc && avs_read) begin
      case (avs_address)
        ISC_AV_CMD: avs_readdata <= {23'h000000, cmd_q};
        ISC_AV_WDATA: avs_readdata <= {16'h0000, wdata_q};
        ISC_AV_RESULT: avs_readdata <= {15'h0000, state_q != ISC_H_IDLE, result_q};
        ISC_AV_IRQ_STATUS: avs_readdata <= {30'h00000000, irq_status_q};
        ISC_AV_IRQ_ENABLE: avs_readdata <= {30'h00000000, irq_enable_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reserved bit handling on outgoing writes
  // ----------------------------------------------------------------
  always_comb begin
    send_data = wdata_q;
    if (cmd_q[7:0] == ISC_ERR_CFG_ADDR) begin
      send_data[ISC_ERR_RSVD_BIT] = 1'b0;
    end
    if (cmd_q[7:0] == ISC_MAIN_CFG_ADDR) begin
      send_data[ISC_CFG_RSVD_BIT] = 1'b0;
      send_data[5:0] = ISC_CFG_LOW_RSVD;
      if (scan_shadow_q) begin
        send_data[ISC_BOOST_CH0] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_shadow_q <= 1'b0;
    end else if (go && !cmd_q[ISC_CMD_READ_BIT] && cmd_q[7:0] == ISC_MUX_CFG_ADDR) begin
      scan_shadow_q <= wdata_q[ISC_SCAN_EN];
    end
  end

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ISC_H_IDLE;
      link.addr <= 8'h00;
      link.wdata <= 16'h0000;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      result_q <= 16'h0000;
    end else begin
      case (state_q)
        ISC_H_IDLE: begin
          if (go) begin
            link.addr <= cmd_q[7:0];
            link.wdata <= send_data;
            link.wr <= !cmd_q[ISC_CMD_READ_BIT];
            link.rd <= cmd_q[ISC_CMD_READ_BIT];
            state_q <= ISC_H_REQ;
          end
        end
        ISC_H_REQ: begin
          if (link.ack) begin
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            if (link.rd) begin
              result_q <= link.rdata;
            end
            state_q <= ISC_H_DONE;
          end
        end
        ISC_H_DONE: begin
          state_q <= ISC_H_IDLE;
        end
        default: begin
          state_q <= ISC_H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_sync_q <= 2'h3;
      pin_prev_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[0], link.irq_line};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  assign done_ev = state_q == ISC_H_DONE;
  assign irq_ev = pin_prev_q && !pin_sync_q[1];

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == ISC_EV_DONE && done_ev) || (i == ISC_EV_DEV_IRQ && irq_ev)) begin
          irq_status_q[i] <= 1'b1;
        end else if (wr_acc && avs_address == ISC_AV_IRQ_CLEAR && avs_writedata[i]) begin
          irq_status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

endmodule : isc_host

/* File: isc_asserts.sv */
`timescale 1ns/1ps
module isc_asserts import isc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic irq_o,
  input wire logic irq_oe_n,
  input wire logic irq_line
);
  // ----------------------------------------------------------------
  // shadow of the device registers, taken from link writes
  // ----------------------------------------------------------------
  logic [15:0] err_q, main_q, mux_q;
  logic routed_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_q <= ISC_ERR_CFG_RST;
      main_q <= ISC_MAIN_CFG_RST;
      mux_q <= ISC_MUX_CFG_RST;
    end else if (wr && !ack) begin
      if (addr == ISC_ERR_CFG_ADDR) err_q <= wdata;
      if (addr == ISC_MAIN_CFG_ADDR) main_q <= wdata;
      if (addr == ISC_MUX_CFG_ADDR) mux_q <= wdata;
    end
  end

  // sticky: no flag can exist before some routing bit was ever set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) routed_q <= 1'b0;
    else if (err_q[3] || err_q[2] || err_q[0]) routed_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_ack_single: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  a_ack_prompt: assert property ((wr || rd) && !ack |=> ack) else $error("ack late");
  a_ack_has_req: assert property (ack |-> (wr || rd)) else $error("ack without request");
  a_dir_exclusive: assert property (!(wr && rd)) else $error("read and write together");
  a_open_drain: assert property (!irq_oe_n |-> !irq_o) else $error("pin driven high");
  a_unrouted_quiet: assert property (!routed_q |-> irq_oe_n)
    else $error("pin low with nothing routed");
  a_pin_disable: assert property (main_q[7] && $past(main_q[7]) |-> irq_oe_n)
    else $error("pin low while disabled");
  a_main_readback: assert property (rd && ack && addr == ISC_MAIN_CFG_ADDR |-> rdata == main_q)
    else $error("main config readback wrong");
  a_err_readback: assert property (rd && ack && addr == ISC_ERR_CFG_ADDR |->
    rdata[3:0] == err_q[3:0]) else $error("error config readback wrong");
  a_mux_readback: assert property (rd && ack && addr == ISC_MUX_CFG_ADDR |->
    {rdata[15:13], rdata[2:0]} == {mux_q[15:13], mux_q[2:0]}) else $error("mux readback wrong");
  a_unmapped_zero: assert property (rd && ack && (addr < 8'h18 || addr > 8'h1B) |->
    rdata == 16'h0000) else $error("unmapped read not zero");
endmodule : isc_asserts

/* File: test_inductive_sensor_config_regs.sv */
`timescale 1ns/1ps
module test_inductive_sensor_config_regs import isc_pkg::*; ();
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq;
  logic amp_low_evt = 1'b0;
  logic zero_count_evt = 1'b0;
  logic conv_done_evt = 1'b0;
  logic [1:0] conv_channel;
  logic sleep_mode, drive_current_override_enable, sensor_startup_mode_select;
  logic amplitude_correction_disable, measured_drive_update_en, reference_source_select;
  logic boosted_drive_ch0;
  logic [2:0] deglitch_select;
  logic [2:0] dg [4] = '{3'h1, 3'h4, 3'h5, 3'h7};
  int mismatches = 0;
  int checks_done = 0;
  int upd_cnt = 0;
  int seed = 32'h1082F0BA;
  logic [31:0] t;
  logic [15:0] q;

  isc_link_if link ();
  isc_host i_isc_host (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link));
  isc_device #(.NUM_CHANNELS(4)) i_isc_device (.clk(clk), .reset(reset), .link(link),
    .amp_low_evt(amp_low_evt), .zero_count_evt(zero_count_evt), .conv_done_evt(conv_done_evt),
    .conv_channel(conv_channel), .sleep_mode(sleep_mode),
    .drive_current_override_enable(drive_current_override_enable),
    .sensor_startup_mode_select(sensor_startup_mode_select),
    .amplitude_correction_disable(amplitude_correction_disable),
    .measured_drive_update_en(measured_drive_update_en),
    .reference_source_select(reference_source_select), .boosted_drive_ch0(boosted_drive_ch0),
    .deglitch_select(deglitch_select));
  isc_asserts i_isc_asserts (.clk(clk), .reset(reset), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .ack(link.ack), .rdata(link.rdata), .irq_o(link.irq_o),
    .irq_oe_n(link.irq_oe_n), .irq_line(link.irq_line));

  initial forever #20 clk = ~clk;
  always @(posedge clk) if (measured_drive_update_en === 1'b1) upd_cnt++;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // one avalon access; request held until waitrequest seen low
  task av(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  // one link transfer through the host registers
  task lk(input logic rdn, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    logic [31:0] x;
    av(1'b1, ISC_AV_CMD, {23'h0, rdn, a}, x);
    if (!rdn) av(1'b1, ISC_AV_WDATA, {16'h0, d}, x);
    av(1'b1, ISC_AV_GO, 32'h0, x);
    do begin
      av(1'b0, ISC_AV_RESULT, 32'h0, x);
    end while (x[ISC_RES_BUSY_BIT] !== 1'b0);
    r = x[15:0];
  endtask : lk

  task fire(input logic [2:0] m);
    @(posedge clk);
    {amp_low_evt, zero_count_evt, conv_done_evt} <= m;
    @(posedge clk);
    {amp_low_evt, zero_count_evt, conv_done_evt} <= 3'h0;
  endtask : fire

  function logic [15:0] exp_main(input logic [15:0] d, input logic scan);
    return {d[15:9], 1'b0, d[7], d[6] & ~scan, ISC_CFG_LOW_RSVD};
  endfunction : exp_main

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] m;
    logic [15:0] d;
    int n;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    chk({sleep_mode, sensor_startup_mode_select, deglitch_select, conv_channel,
      drive_current_override_enable, amplitude_correction_disable, reference_source_select,
      boosted_drive_ch0, link.irq_line}, 32'hF81);
    lk(1'b1, ISC_ERR_CFG_ADDR, 16'h0, q); chk(q, ISC_ERR_CFG_RST);
    lk(1'b1, ISC_MAIN_CFG_ADDR, 16'h0, q); chk(q, ISC_MAIN_CFG_RST);
    lk(1'b1, ISC_MUX_CFG_ADDR, 16'h0, q); chk(q, ISC_MUX_CFG_RST);
    av(1'b0, 3'h7, 32'h0, t); chk(t, 32'h0);
    lk(1'b1, 8'h05, 16'h0, q); chk(q, 32'h0);
    // host interrupt: clear, raise, mask, clear
    av(1'b1, ISC_AV_IRQ_ENABLE, 32'h1, t);
    av(1'b1, ISC_AV_IRQ_CLEAR, 32'h3, t);
    repeat (2) @(posedge clk); chk(irq, 32'h0);
    lk(1'b1, ISC_MUX_CFG_ADDR, 16'h0, q);
    repeat (2) @(posedge clk); chk(irq, 32'h1);
    av(1'b0, ISC_AV_IRQ_STATUS, 32'h0, t); chk(t[ISC_EV_DONE], 32'h1);
    av(1'b1, ISC_AV_IRQ_ENABLE, 32'h0, t);
    repeat (2) @(posedge clk); chk(irq, 32'h0);
    av(1'b1, ISC_AV_IRQ_ENABLE, 32'h1, t);
    av(1'b1, ISC_AV_IRQ_CLEAR, 32'h1, t);
    repeat (2) @(posedge clk); chk(irq, 32'h0);
    av(1'b1, ISC_AV_IRQ_ENABLE, 32'h0, t);
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($random(seed));
      lk(1'b0, ISC_MAIN_CFG_ADDR, d, q);
      lk(1'b1, ISC_MAIN_CFG_ADDR, 16'h0, q);
      chk(q, exp_main(d, 1'b0));
      chk({conv_channel, sleep_mode, drive_current_override_enable, sensor_startup_mode_select,
        amplitude_correction_disable, reference_source_select, boosted_drive_ch0},
        {d[15:9], d[6]});
    end
    lk(1'b0, ISC_MAIN_CFG_ADDR, 16'h0001, q);
    upd_cnt = 0; fire(3'h1); repeat (3) @(posedge clk); chk(upd_cnt, 32'h1);
    lk(1'b0, ISC_MAIN_CFG_ADDR, 16'h0401, q);
    upd_cnt = 0; fire(3'h1); repeat (3) @(posedge clk); chk(upd_cnt, 32'h0);
    lk(1'b0, ISC_MAIN_CFG_ADDR, 16'h0001, q);
    for (int i = 0; i < 8; i++) begin
      m = (i == 7) ? 3'h7 : 3'($random(seed));
      lk(1'b0, ISC_ERR_CFG_ADDR, {12'h0, i[2:1], 1'b0, i[0]}, q);
      lk(1'b1, ISC_STATUS_ADDR, 16'h0, q);
      fire(m);
      repeat (3) @(posedge clk);
      chk(link.irq_line, ~|(m & i[2:0]));
      lk(1'b1, ISC_STATUS_ADDR, 16'h0, q);
      chk(q & 16'h0340, {6'h0, m[2] & i[2], m[1] & i[1], 1'b0, m[0] & i[0], 6'h0});
      chk(link.irq_line, 32'h1);
    end
    // last sweep pass pulled the pin low, so the host saw a falling edge
    av(1'b0, ISC_AV_IRQ_STATUS, 32'h0, t); chk(t[ISC_EV_DEV_IRQ], 32'h1);
    lk(1'b0, ISC_MAIN_CFG_ADDR, 16'h0081, q);
    fire(3'h7); repeat (3) @(posedge clk); chk(link.irq_line, 32'h1);
    lk(1'b0, ISC_MAIN_CFG_ADDR, 16'h0001, q);
    repeat (2) @(posedge clk); chk(link.irq_line, 32'h0);
    lk(1'b1, ISC_STATUS_ADDR, 16'h0, q);
    // mux codes, boost blocked while scanning
    for (int j = 0; j < 4; j++) begin
      d = {j[0], j[1], j[0], 10'h041, dg[j]};
      lk(1'b0, ISC_MUX_CFG_ADDR, d, q);
      lk(1'b1, ISC_MUX_CFG_ADDR, 16'h0, q); chk(q, d);
      lk(1'b0, ISC_MAIN_CFG_ADDR, 16'h0041, q);
      lk(1'b1, ISC_MAIN_CFG_ADDR, 16'h0, q);
      chk({q[6], boosted_drive_ch0, deglitch_select}, {~j[0], ~j[0], dg[j]});
      // scan steps, data-ready only at sequence end
      n = j[0] ? ((j == 1) ? 3 : 2) : 1;
      for (int s = 1; s < 5; s++) begin
        fire(3'h1);
        repeat (2) @(posedge clk);
        chk({conv_channel, link.irq_line}, {2'(s % n), s < n});
      end
      lk(1'b1, ISC_STATUS_ADDR, 16'h0, q);
    end
    conclude();
  end

  // hang guard, far beyond the roughly one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : test_inductive_sensor_config_regs
